// file: phe_top.sv
// Parity generators, checkers and Hamming encoders/decoders
`default_nettype none

// ----------------------------------------------------------------
// Parity tree unit: modulo-two sum of up to twelve inputs
// ----------------------------------------------------------------
module phe_par_unit (
    input wire logic [phe_pkg::PAR_UNIT_W-1:0] bits_in,
    output logic odd_out
);
    localparam int L = phe_pkg::PAR_TREE_LEAVES;
    logic [2*L-2:0] node;

    // Leaves padded with four zeros, which leaves parity intact
    assign node[2*L-2:L-1] = {{(L-phe_pkg::PAR_UNIT_W){1'b0}}, bits_in};

    // Heap-ordered XOR stages, four levels deep
    genvar i;
    generate
        for (i = 0; i < L - 1; i++) begin : g_stage
            assign node[i] = node[2*i+1] ^ node[2*i+2];
        end
    endgenerate

    assign odd_out = node[0]; // High on odd count of ones
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module phe_top #(
    parameter int CASC_W = phe_pkg::CASC_W_DEF
) (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic EVEN_MODE_IN,
    input wire logic [phe_pkg::PAR_UNIT_W-1:0] PAR_DATA_IN,
    output logic PAR_ODD_OUT,
    output logic PAR_EVEN_OUT,
    input wire logic [CASC_W-1:0] CASC_DATA_IN,
    output logic CASC_ODD_OUT,
    output logic CASC_EVEN_OUT,
    input wire phe_pkg::phe_ser_s TX_S_IN,
    output logic TX_SER_OUT,
    output logic TX_SER_VLD_OUT,
    output logic TX_PAR_SLOT_OUT,
    input wire phe_pkg::phe_ser_s RX_S_IN,
    output logic RX_DONE_OUT,
    output logic RX_PAR_ERR_OUT,
    input wire logic [3:0] H7_DATA_IN,
    output logic [phe_pkg::H7_OVP_POS:0] H7_CODE_OUT,
    input wire logic [phe_pkg::H7_OVP_POS:0] H7_RCV_IN,
    input wire logic H7_OVP_EN_IN,
    input wire logic H7_ALT_IN,
    output phe_pkg::phe_h7_res_s H7_RES_OUT,
    input wire logic [phe_pkg::HW_DATA-1:0] HW_DATA_IN,
    output logic [phe_pkg::HW_CODE-1:0] HW_CODE_OUT,
    input wire logic [phe_pkg::HW_CODE-1:0] HW_RCV_IN,
    output phe_pkg::phe_hw_res_s HW_RES_OUT
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int UW = phe_pkg::PAR_UNIT_W;

    // Second unit takes the first unit's parity plus up to eleven bits
    generate
        if (CASC_W <= UW || CASC_W > 2 * UW - 1) begin : g_bad_casc
            $error("CASC_W must lie between 13 and 23");
        end
        if (phe_pkg::HW_CODE - phe_pkg::HW_DATA != phe_pkg::HW_CHK ||
            phe_pkg::HW_CODE > phe_pkg::H_M5_TOTAL ||
            phe_pkg::HW_DATA > phe_pkg::H_M5_DATA) begin : g_bad_hw
            $error("Wide code exceeds the five check bit size");
        end
        if (phe_pkg::H7_OVP_POS != phe_pkg::H_M3_TOTAL ||
            phe_pkg::H_M3_DATA + phe_pkg::H7_CHK !=
            phe_pkg::H_M3_TOTAL ||
            phe_pkg::H_M4_DATA + 4 != phe_pkg::H_M4_TOTAL) begin : g_bad_h7
            $error("Seven bit code sizing mismatch");
        end
    endgenerate

    // ------------------------------------------------------------
    // Functions for the Hamming paths
    // ------------------------------------------------------------

    // Odd-parity check bits, data d[3:0]
    function automatic logic [2:0] h7_chk(input logic [3:0] d);
        h7_chk[0] = ~(d[0] ^ d[1] ^ d[3]);
        h7_chk[1] = ~(d[0] ^ d[2] ^ d[3]);
        h7_chk[2] = ~(d[1] ^ d[2] ^ d[3]);
    endfunction

    // Wide code: check bits at powers of two, data fills the rest
    function automatic logic [phe_pkg::HW_CODE-1:0] hw_enc(
        input logic [phe_pkg::HW_DATA-1:0] d);
        logic [phe_pkg::HW_CODE-1:0] c;
        int j;
        c = '0;
        j = 0;
        for (int p = 1; p <= phe_pkg::HW_CODE; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p-1] = d[j];
                j++;
            end
        end
        for (int k = 0; k < phe_pkg::HW_CHK; k++) begin
            c[(1 << k) - 1] = 1'b1; // Odd parity seed
            for (int p = 1; p <= phe_pkg::HW_CODE; p++) begin
                if (((p >> k) & 1) == 1 && p != (1 << k)) begin
                    c[(1 << k) - 1] = c[(1 << k) - 1] ^ c[p-1];
                end
            end
        end
        return c;
    endfunction

    // Extract the data bits from a wide code word
    function automatic logic [phe_pkg::HW_DATA-1:0] hw_data(
        input logic [phe_pkg::HW_CODE-1:0] c);
        logic [phe_pkg::HW_DATA-1:0] d;
        int j;
        d = '0;
        j = 0;
        for (int p = 1; p <= phe_pkg::HW_CODE; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[j] = c[p-1];
                j++;
            end
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // Parallel parity: single unit and cascade
    // ------------------------------------------------------------
    logic unit_odd;
    logic casc_lo_odd;
    logic casc_odd;
    logic [UW-1:0] casc_hi_bits;

    phe_par_unit u_par (
        .bits_in(PAR_DATA_IN),
        .odd_out(unit_odd)
    );

    phe_par_unit u_casc_lo (
        .bits_in(CASC_DATA_IN[UW-1:0]),
        .odd_out(casc_lo_odd)
    );

    // Low unit's parity feeds an input of the high unit
    assign casc_hi_bits = {{(2 * UW - 1 - CASC_W){1'b0}},
                           CASC_DATA_IN[CASC_W-1:UW], casc_lo_odd};

    phe_par_unit u_casc_hi (
        .bits_in(casc_hi_bits),
        .odd_out(casc_odd)
    );

    // Even outputs come from the odd result through an inverter
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            PAR_ODD_OUT <= phe_pkg::RST_ODD_OUT;
            PAR_EVEN_OUT <= phe_pkg::RST_EVEN_OUT;
            CASC_ODD_OUT <= phe_pkg::RST_ODD_OUT;
            CASC_EVEN_OUT <= phe_pkg::RST_EVEN_OUT;
        end else begin
            PAR_ODD_OUT <= unit_odd;
            PAR_EVEN_OUT <= ~unit_odd;
            CASC_ODD_OUT <= casc_odd;
            CASC_EVEN_OUT <= ~casc_odd;
        end
    end

    // ------------------------------------------------------------
    // Serial parity generator
    // ------------------------------------------------------------
    logic tx_tog_reg;
    logic tx_pend_reg;
    logic tx_tog_next;
    logic tx_take;

    // Bits offered in the parity slot are ignored, never merged
    assign tx_take = TX_S_IN.valid && !tx_pend_reg;
    assign tx_tog_next = tx_tog_reg ^ (tx_take && TX_S_IN.data);

    // Toggle per one; clear on word start or after parity
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            tx_tog_reg <= phe_pkg::RST_TOGGLE;
        end else if (tx_pend_reg) begin
            tx_tog_reg <= phe_pkg::RST_TOGGLE;
        end else if (TX_S_IN.clr) begin
            tx_tog_reg <= TX_S_IN.valid & TX_S_IN.data;
        end else begin
            tx_tog_reg <= tx_tog_next;
        end
    end

    // Serial output: data bits, then the trailing parity bit
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            tx_pend_reg <= 1'b0;
            TX_SER_OUT <= 1'b0;
            TX_SER_VLD_OUT <= 1'b0;
            TX_PAR_SLOT_OUT <= 1'b0;
        end else begin
            tx_pend_reg <= tx_take && TX_S_IN.last;
            TX_PAR_SLOT_OUT <= tx_pend_reg;
            TX_SER_VLD_OUT <= tx_take || tx_pend_reg;
            if (tx_pend_reg) begin
                // Odd mode inverts the count so the total is odd
                TX_SER_OUT <= tx_tog_reg ^ ~EVEN_MODE_IN;
            end else begin
                TX_SER_OUT <= tx_take && TX_S_IN.data;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial parity checker
    // ------------------------------------------------------------
    logic rx_tog_reg;
    logic rx_tog_next;

    // Clear on word start so the first bit counts from zero
    assign rx_tog_next = (RX_S_IN.clr ? phe_pkg::RST_TOGGLE : rx_tog_reg)
                         ^ (RX_S_IN.valid && RX_S_IN.data);

    // Toggle over all received bits, parity bit included
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            rx_tog_reg <= phe_pkg::RST_TOGGLE;
        end else if (RX_S_IN.valid && RX_S_IN.last) begin
            rx_tog_reg <= phe_pkg::RST_TOGGLE;
        end else begin
            rx_tog_reg <= rx_tog_next;
        end
    end

    // Verdict only once the parity bit is
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            RX_DONE_OUT <= 1'b0;
            RX_PAR_ERR_OUT <= 1'b0;
        end else begin
            RX_DONE_OUT <= RX_S_IN.valid && RX_S_IN.last;
            if (RX_S_IN.valid && RX_S_IN.last) begin
                // Any single flip breaks the expected count
                RX_PAR_ERR_OUT <= rx_tog_next ^ ~EVEN_MODE_IN;
            end
        end
    end

    // ------------------------------------------------------------
    // Seven-bit Hamming encoder
    // ------------------------------------------------------------
    logic [2:0] enc_chk;
    logic [phe_pkg::H7_OVP_POS-1:0] enc_code;

    assign enc_chk = h7_chk(H7_DATA_IN);
    // Order c0 c1 d0 c2 d1 d2 d3 from bit 0 upward
    assign enc_code = {H7_DATA_IN[3:1], enc_chk[2], H7_DATA_IN[0],
                       enc_chk[1:0]};

    // Overall odd-parity bit sits above the seven code bits
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            H7_CODE_OUT <= '0;
        end else begin
            H7_CODE_OUT <= {~(^enc_code), enc_code};
        end
    end

    // ------------------------------------------------------------
    // Seven-bit Hamming decoder
    // ------------------------------------------------------------
    logic [3:0] rd;
    logic [2:0] rc;
    logic [2:0] syn_direct;
    logic [2:0] syn_alt;
    logic [2:0] syn;
    logic [phe_pkg::H7_OVP_POS-1:0] flip;
    logic ovp_ok;
    phe_pkg::phe_h7_res_s h7_next;

    assign rd = {H7_RCV_IN[6:4], H7_RCV_IN[2]};
    assign rc = {H7_RCV_IN[3], H7_RCV_IN[1:0]};

    // Received check bits join the parity sums
    assign syn_direct[0] = ~(rc[0] ^ rd[0] ^ rd[1] ^ rd[3]);
    assign syn_direct[1] = ~(rc[1] ^ rd[0] ^ rd[2] ^ rd[3]);
    assign syn_direct[2] = ~(rc[2] ^ rd[1] ^ rd[2] ^ rd[3]);
    // Regenerated checks compared with received ones
    assign syn_alt = h7_chk(rd) ^ rc;
    assign syn = H7_ALT_IN ? syn_alt : syn_direct;
    // A correct word carries an odd count over all eight bits
    assign ovp_ok = ^H7_RCV_IN;

    // Classify and correct; syndrome names the bit position
    always_comb begin
        logic fix;
        fix = 1'b0;
        h7_next = '0;
        h7_next.syn = syn;
        if (!H7_OVP_EN_IN) begin
            // No double detection: a double error miscorrects
            fix = (syn != 3'h0);
            h7_next.single = fix;
        end else if (ovp_ok && syn != 3'h0) begin
            h7_next.double = 1'b1; // Left uncorrected
        end else if (!ovp_ok) begin
            // Zero syndrome here means the overall bit flipped
            fix = (syn != 3'h0);
            h7_next.single = 1'b1;
        end
        flip = '0;
        if (fix) begin
            flip[syn - 3'h1] = 1'b1;
        end
        h7_next.data = rd ^ {flip[6:4], flip[2]};
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            H7_RES_OUT <= '0;
        end else begin
            H7_RES_OUT <= h7_next;
        end
    end

    // ------------------------------------------------------------
    // Wide Hamming encoder and corrector
    // ------------------------------------------------------------
    logic [phe_pkg::HW_CHK-1:0] hw_syn;
    logic [phe_pkg::HW_ONEHOT-1:0] hw_sel;
    logic [phe_pkg::HW_CODE-1:0] hw_fixed;
    phe_pkg::phe_hw_res_s hw_next;

    // Each syndrome bit covers positions with that address bit
    always_comb begin
        for (int k = 0; k < phe_pkg::HW_CHK; k++) begin
            hw_syn[k] = 1'b1;
            for (int p = 1; p <= phe_pkg::HW_CODE; p++) begin
                if (((p >> k) & 1) == 1) begin
                    hw_syn[k] = hw_syn[k] ^ HW_RCV_IN[p-1];
                end
            end
        end
    end

    // One-of-32 decode; line zero and lines past the code fix nothing
    assign hw_sel = phe_pkg::HW_ONEHOT'(1) << hw_syn;
    assign hw_fixed = HW_RCV_IN ^ hw_sel[phe_pkg::HW_CODE:1];

    always_comb begin
        hw_next.data = hw_data(hw_fixed);
        hw_next.syn = hw_syn;
        hw_next.fixed = (hw_syn != '0) &&
                        (hw_syn <= phe_pkg::HW_CHK'(phe_pkg::HW_CODE));
        // Positions above the code cannot be a single error
        hw_next.bad = (hw_syn > phe_pkg::HW_CHK'(phe_pkg::HW_CODE));
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            HW_CODE_OUT <= '0;
            HW_RES_OUT <= '0;
        end else begin
            HW_CODE_OUT <= hw_enc(HW_DATA_IN);
            HW_RES_OUT <= hw_next;
        end
    end

endmodule

`default_nettype wire

// file: phe_pkg.sv
// Constants and carrier types for the parity and Hamming block
`default_nettype none

package phe_pkg;

    // ------------------------------------------------------------
    // Parity unit and cascade sizes
    // ------------------------------------------------------------
    localparam int PAR_UNIT_W = 12;
    localparam int PAR_TREE_LEAVES = 16;
    localparam int CASC_W_DEF = 23;

    // ------------------------------------------------------------
    // Hamming configurations: total, check and data bits
    // ------------------------------------------------------------
    localparam int H_M3_TOTAL = 7;
    localparam int H_M3_DATA = 4;
    localparam int H_M4_TOTAL = 15;
    localparam int H_M4_DATA = 11;
    localparam int H_M5_TOTAL = 31;
    localparam int H_M5_DATA = 26;
    localparam int H7_CHK = 3;
    localparam int H7_OVP_POS = 7;
    localparam int HW_CHK = 5;
    localparam int HW_DATA = 20;
    localparam int HW_CODE = 25;
    localparam int HW_ONEHOT = 32;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_TOGGLE = 1'h0;
    localparam logic RST_ODD_OUT = 1'h0;
    localparam logic RST_EVEN_OUT = 1'h1;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic clr;
        logic valid;
        logic data;
        logic last;
    } phe_ser_s;

    typedef struct packed {
        logic [3:0] data;
        logic [2:0] syn;
        logic single;
        logic double;
    } phe_h7_res_s;

    typedef struct packed {
        logic [HW_DATA-1:0] data;
        logic [HW_CHK-1:0] syn;
        logic fixed;
        logic bad;
    } phe_hw_res_s;

endpackage

`default_nettype wire

// file: phe_properties.sv
// Port-level checker for the parity and Hamming block
`default_nettype none
module phe_properties #(
    parameter int CASC_W = 23
) (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic [phe_pkg::PAR_UNIT_W-1:0] PAR_DATA_IN,
    input wire logic PAR_ODD_OUT,
    input wire logic PAR_EVEN_OUT,
    input wire logic [CASC_W-1:0] CASC_DATA_IN,
    input wire logic CASC_ODD_OUT,
    input wire logic CASC_EVEN_OUT,
    input wire phe_pkg::phe_ser_s TX_S_IN,
    input wire logic TX_SER_VLD_OUT,
    input wire logic TX_PAR_SLOT_OUT,
    input wire phe_pkg::phe_ser_s RX_S_IN,
    input wire logic RX_DONE_OUT,
    input wire logic [3:0] H7_DATA_IN,
    input wire logic [phe_pkg::H7_OVP_POS:0] H7_CODE_OUT,
    input wire logic [phe_pkg::H7_OVP_POS:0] H7_RCV_IN,
    input wire phe_pkg::phe_h7_res_s H7_RES_OUT,
    input wire phe_pkg::phe_hw_res_s HW_RES_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    logic rst_q;
    logic [3:0] d_q;
    logic [7:0] r_q;
    // Delayed copies; outputs lag their inputs by one edge
    always_ff @(posedge CLK_IN) begin
        rst_q <= SRST_IN;
        d_q <= H7_DATA_IN;
        r_q <= H7_RCV_IN;
    end
    sequence s_tx_last;
        TX_S_IN.valid && TX_S_IN.last;
    endsequence
    sequence s_rx_last;
        RX_S_IN.valid && RX_S_IN.last;
    endsequence
    a_par_odd_count: assert property (!rst_q |->
        PAR_ODD_OUT == ^$past(PAR_DATA_IN)) else $error("parity odd");
    a_par_even_inverse: assert property (
        PAR_EVEN_OUT != PAR_ODD_OUT) else $error("even not inverse");
    a_casc_wide_parity: assert property (!rst_q |->
        CASC_ODD_OUT == ^$past(CASC_DATA_IN) &&
        CASC_EVEN_OUT != CASC_ODD_OUT) else $error("cascade parity");
    a_h7_code_layout: assert property (!rst_q |-> ^H7_CODE_OUT &&
        H7_CODE_OUT[6:4] == d_q[3:1] && H7_CODE_OUT[2] == d_q[0])
        else $error("code layout");
    a_h7_check_bits: assert property (!rst_q |->
        H7_CODE_OUT[1:0] == {~^{d_q[0], d_q[2], d_q[3]},
        ~^{d_q[0], d_q[1], d_q[3]}} && H7_CODE_OUT[3] == ~^d_q[3:1])
        else $error("check bits");
    a_h7_syndrome_bits: assert property (!rst_q |->
        H7_RES_OUT.syn == {~^{r_q[3], r_q[4], r_q[5], r_q[6]},
        ~^{r_q[1], r_q[2], r_q[5], r_q[6]},
        ~^{r_q[0], r_q[2], r_q[4], r_q[6]}}) else $error("syndrome");
    a_h7_double_nofix: assert property (H7_RES_OUT.double |->
        !H7_RES_OUT.single && H7_RES_OUT.syn != 3'h0 &&
        H7_RES_OUT.data == {r_q[6], r_q[5], r_q[4], r_q[2]})
        else $error("double fixed");
    a_tx_parity_slot: assert property (s_tx_last |->
        ##2 (TX_PAR_SLOT_OUT && TX_SER_VLD_OUT)) else $error("no slot");
    a_rx_done_after: assert property (s_rx_last |=>
        RX_DONE_OUT) else $error("no verdict");
    a_rx_done_cause: assert property (RX_DONE_OUT |->
        !rst_q && $past(RX_S_IN.valid && RX_S_IN.last))
        else $error("early verdict");
    a_hw_zero_clean: assert property (HW_RES_OUT.syn == 5'h00 |->
        !HW_RES_OUT.fixed && !HW_RES_OUT.bad) else $error("zero syn");
    a_hw_fix_range: assert property (HW_RES_OUT.fixed |->
        HW_RES_OUT.syn inside {[5'h01:5'h19]} && !HW_RES_OUT.bad)
        else $error("fix range");
endmodule
bind phe_top phe_properties #(.CASC_W(CASC_W)) u_chk (.CLK_IN(CLK_IN),
    .SRST_IN(SRST_IN), .PAR_DATA_IN(PAR_DATA_IN), .PAR_ODD_OUT(PAR_ODD_OUT),
    .PAR_EVEN_OUT(PAR_EVEN_OUT), .CASC_DATA_IN(CASC_DATA_IN),
    .CASC_ODD_OUT(CASC_ODD_OUT), .CASC_EVEN_OUT(CASC_EVEN_OUT),
    .TX_S_IN(TX_S_IN), .TX_SER_VLD_OUT(TX_SER_VLD_OUT),
    .TX_PAR_SLOT_OUT(TX_PAR_SLOT_OUT), .RX_S_IN(RX_S_IN),
    .RX_DONE_OUT(RX_DONE_OUT), .H7_DATA_IN(H7_DATA_IN),
    .H7_CODE_OUT(H7_CODE_OUT), .H7_RCV_IN(H7_RCV_IN),
    .H7_RES_OUT(H7_RES_OUT), .HW_RES_OUT(HW_RES_OUT));
`default_nettype wire

// file: phe_link_model.sv
// Serial link model carrying the transmitted word to the receiver
`default_nettype none
module phe_link_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic bit_in,
    input wire logic vld_in,
    input wire logic slot_in,
    input wire logic flip_in,
    output phe_pkg::phe_ser_s rx_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic first_reg;
    logic hold_reg;
    // A word starts after reset and after every parity slot
    always_ff @(posedge clk_in) begin
        if (srst_in || (vld_in && slot_in)) begin
            first_reg <= 1'b1;
        end else if (vld_in) begin
            first_reg <= 1'b0;
        end
    end
    // Idle line shows the inverse of the last bit, never a stale copy
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hold_reg <= 1'b0;
        end else if (vld_in) begin
            hold_reg <= ~rx_out.data;
        end
    end
    // Flip only the parity bit, a single error the checker must see
    assign rx_out.data = vld_in ? bit_in ^ (flip_in & slot_in) : hold_reg;
    assign rx_out.valid = vld_in;
    assign rx_out.clr = vld_in & first_reg;
    assign rx_out.last = vld_in & slot_in;
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the parity and Hamming block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, srst, even_mode, flip, ovp, alt, par_odd, par_even;
    logic casc_odd, casc_even, tx_bit, tx_vld, tx_slot, rx_done, rx_err;
    logic [11:0] par_data;
    logic [22:0] casc_data;
    logic [3:0] h7_data;
    logic [7:0] h7_code, h7_rcv;
    logic [19:0] hw_data;
    logic [24:0] hw_code, hw_rcv;
    phe_pkg::phe_ser_s tx_s, rx_s;
    phe_pkg::phe_h7_res_s h7_res;
    phe_pkg::phe_hw_res_s hw_res;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    phe_top #(.CASC_W(23)) i_dut (.CLK_IN(clk), .SRST_IN(srst),
        .EVEN_MODE_IN(even_mode), .PAR_DATA_IN(par_data),
        .PAR_ODD_OUT(par_odd), .PAR_EVEN_OUT(par_even),
        .CASC_DATA_IN(casc_data), .CASC_ODD_OUT(casc_odd),
        .CASC_EVEN_OUT(casc_even), .TX_S_IN(tx_s), .TX_SER_OUT(tx_bit),
        .TX_SER_VLD_OUT(tx_vld), .TX_PAR_SLOT_OUT(tx_slot), .RX_S_IN(rx_s),
        .RX_DONE_OUT(rx_done), .RX_PAR_ERR_OUT(rx_err),
        .H7_DATA_IN(h7_data), .H7_CODE_OUT(h7_code), .H7_RCV_IN(h7_rcv),
        .H7_OVP_EN_IN(ovp), .H7_ALT_IN(alt), .H7_RES_OUT(h7_res),
        .HW_DATA_IN(hw_data), .HW_CODE_OUT(hw_code), .HW_RCV_IN(hw_rcv),
        .HW_RES_OUT(hw_res));
    phe_link_model i_link (.clk_in(clk), .srst_in(srst), .bit_in(tx_bit),
        .vld_in(tx_vld), .slot_in(tx_slot), .flip_in(flip), .rx_out(rx_s));
    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic t_par();
        logic [11:0] pv [7] = '{12'h000, 12'hFFF, 12'h001, 12'h800,
            12'h1FF, 12'h6A5, 12'hC35};
        for (int i = 0; i < 7; i++) begin
            @(negedge clk);
            par_data = pv[i];
            casc_data = {pv[i][10:0], pv[i]} ^ 23'(i);
            @(negedge clk);
            chk_vec(32'(par_odd), 32'(^pv[i]));
            chk_vec(32'(par_even), 32'(~^pv[i]));
            chk_vec(32'({casc_odd, casc_even}), 32'({^casc_data,
                ~^casc_data}));
        end
    endtask
    task automatic t_ser(input logic [7:0] w, input logic em, fl);
        int n;
        @(negedge clk);
        even_mode = em;
        flip = fl;
        // Back to back bits, clear with the first one
        for (int i = 0; i < 8; i++) begin
            tx_s = {1'(i == 0), 1'b1, w[i], 1'(i == 7)};
            @(negedge clk);
        end
        tx_s = '0;
        n = 0;
        while (tx_slot !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        chk_vec(32'({tx_vld, tx_slot, tx_bit}),
            32'({2'b11, ^w ^ ~em}));
        n = 0;
        while (rx_done !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        chk_vec(32'({rx_done, rx_err}), 32'({1'b1, fl}));
    endtask
    task automatic h7_try(input logic [7:0] r, input logic [8:0] e);
        @(negedge clk);
        h7_rcv = r;
        @(negedge clk);
        chk_vec(32'(h7_res), 32'(e));
    endtask
    task automatic t_h7();
        logic [3:0] d;
        logic [7:0] c;
        for (int k = 0; k < 16; k++) begin
            d = 4'(k);
            c[6:0] = {d[3:1], ~^{d[1], d[2], d[3]}, d[0],
                ~^{d[0], d[2], d[3]}, ~^{d[0], d[1], d[3]}};
            c[7] = ~^c[6:0];
            @(negedge clk);
            h7_data = d;
            ovp = d[0];
            alt = d[1];
            @(negedge clk);
            chk_vec(32'(h7_code), 32'(c));
            h7_try(c, {d, 5'h00});
            for (int b = 0; b < 8; b++) begin
                h7_try(c ^ (8'h01 << b), (b < 7) ? {d, 3'(b + 1), 2'b10} :
                    {d, 3'h0, ovp, 1'b0});
            end
            h7_try(c ^ 8'h03, ovp ? {d, 3'h3, 2'b01} :
                {d ^ 4'h1, 3'h3, 2'b10});
        end
    endtask
    task automatic t_hw(input logic [19:0] d);
        logic [24:0] c;
        logic par;
        int j;
        int sp [5] = '{1, 3, 16, 25, 26};
        logic [24:0] fl [5] = '{25'h1, 25'h4, 25'h8000, 25'h1000000,
            25'h1000004};
        c = '0;
        j = 0;
        for (int p = 1; p <= 25; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p - 1] = d[j];
                j++;
            end
        end
        for (int k = 0; k < 5; k++) begin
            par = 1'b0;
            for (int p = 1; p <= 25; p++) begin
                if (p[k]) par = par ^ c[p - 1];
            end
            c[(1 << k) - 1] = ~par;
        end
        @(negedge clk);
        hw_data = d;
        hw_rcv = c;
        @(negedge clk);
        chk_vec(32'(hw_code), 32'(c));
        chk_vec(32'(hw_res), {5'h00, d, 7'h00});
        // Last entry is a syndrome beyond the code: flagged, not fixed
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            hw_rcv = c ^ fl[i];
            @(negedge clk);
            chk_vec(32'(hw_res), 32'({(i < 4) ? d : d ^ 20'h80001,
                5'(sp[i]), 1'(i < 4), 1'(i == 4)}));
        end
    endtask
    // Bounded run: a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            report_and_stop();
        end
    end
    initial begin
        {srst, even_mode, flip, ovp, alt} = 5'h10;
        {par_data, casc_data, h7_data, h7_rcv} = '0;
        {hw_data, hw_rcv, tx_s} = '0;
        repeat (5) @(negedge clk);
        // Only the even outputs sit high while reset is held
        chk_vec(32'({par_odd, par_even, casc_odd, casc_even, rx_done, rx_err,
            tx_vld, tx_bit, tx_slot, h7_code}), 32'h0000A000);
        chk_vec(32'(h7_res), 32'h00000000);
        chk_vec(32'(hw_res), 32'h00000000);
        chk_vec(32'(hw_code), 32'h00000000);
        srst = 1'b0;
        t_par();
        t_ser(8'hB4, 1'b0, 1'b0);
        t_ser(8'h00, 1'b0, 1'b0);
        t_ser(8'h07, 1'b1, 1'b0);
        t_ser(8'hB4, 1'b0, 1'b1);
        t_ser(8'h5A, 1'b1, 1'b1);
        t_h7();
        t_hw(20'h00000);
        t_hw(20'hA5C3F);
        report_and_stop();
    end
endmodule
`default_nettype wire
